/* File: core/scos_defines.vh */
`ifndef SCOS_DEFINES_VH
`define SCOS_DEFINES_VH
// register byte offsets
`define SCOS_OFF_SEL       12'h000
`define SCOS_OFF_FREQ_CFG  12'h004
`define SCOS_OFF_WIDTH     12'h008
`define SCOS_OFF_DETECT    12'h00C
`define SCOS_OFF_OUTS      12'h010
`define SCOS_OFF_IRQ_STAT  12'h014
`define SCOS_OFF_IRQ_MASK  12'h018
// select field positions in the select register
`define SCOS_SEL_RLY_LSB   0
`define SCOS_SEL_OC_LSB    4
`define SCOS_SEL_OC2_LSB   8
// reset values
`define SCOS_SEL_RST       12'hFFF
`define SCOS_SEL_FIELD_RST 4'hF
`define SCOS_FREQ_RST      16'h0000
`define SCOS_WIDTH_RST     16'h0000
`define SCOS_DETECT_RST    16'h0000
`define SCOS_OTQ_LVL_RST   16'hFFFF
`define SCOS_OTQ_TIME_RST  16'h0000
`define SCOS_MASK_RST      3'h0
// select codes
`define SCOS_C_RUN     4'h0
`define SCOS_C_ZERO    4'h1
`define SCOS_C_AGREE   4'h2
`define SCOS_C_AGPT    4'h3
`define SCOS_C_FDET1   4'h4
`define SCOS_C_FDET2   4'h5
`define SCOS_C_READY   4'h6
`define SCOS_C_UV      4'h7
`define SCOS_C_BB      4'h8
`define SCOS_C_REFOP   4'h9
`define SCOS_C_RUNOP   4'hA
`define SCOS_C_OTQ     4'hB
`define SCOS_C_REFMISS 4'hC
`define SCOS_C_FAULT   4'hE
// detection pulse: 0.1 s at 50 MHz
`define SCOS_PULSE_MS      100
`define SCOS_CLK_KHZ       50000
// 100 ms times 50000 cycles per ms, sized to the hold counter
`define SCOS_PULSE_CYC     23'd5000000
`endif

/* File: core/scos_pulse_stretch.v */
`timescale 1ns/100ps
// holds its output high for a fixed number of cycles after a rising event
module scos_pulse_stretch #(
   parameter [22:0] HOLD_CYC = 23'd5000000
) (
   input wire core_clk,
   input wire nrst,
   input wire event_in,
   output reg stretched
);
   reg event_d;
   reg [22:0] cnt;

   // retrigger restarts the full hold window
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         event_d <= 1'b0;
         cnt <= 23'h000000;
         stretched <= 1'b0;
      end else begin
         event_d <= event_in;
         if (event_in && !event_d) begin
            cnt <= HOLD_CYC - 23'h000001;
            stretched <= 1'b1;
         end else if (cnt != 23'h000000) begin
            cnt <= cnt - 23'h000001;
         end else begin
            stretched <= 1'b0;
         end
      end
   end
endmodule

/* File: core/scos_selector.v */
`timescale 1ns/100ps
`include "scos_defines.vh"
module scos_selector #(
   parameter [22:0] PULSE_CYC = `SCOS_PULSE_CYC
) (
   input wire core_clk,
   input wire nrst,
   // ahb-lite slave
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // drive status
   input wire forward_run_cmd,
   input wire reverse_run_cmd,
   input wire output_voltage_on,
   input wire accel_decel_done,
   input wire [15:0] output_freq,
   input wire [15:0] freq_reference,
   input wire drive_ready,
   input wire undervoltage,
   input wire output_shut_off,
   input wire ref_from_operator,
   input wire run_from_keypad,
   input wire [15:0] output_torque,
   input wire ref_loss,
   input wire major_fault,
   input wire operator_watchdog_fault,
   input wire operator_transmission_fault,
   // terminals and interrupt
   output reg relay_contact_terminal,
   output reg open_collector_terminal,
   output reg second_open_collector_terminal,
   output reg irq
);
   reg [3:0] relay2_output_select;
   reg [3:0] opencollector_output_select;
   reg [3:0] relay1_output_select;
   reg [15:0] min_freq;
   reg [15:0] agreement_point_setting;
   reg [15:0] agreement_width_setting;
   reg [15:0] low_freq_detect_level;
   reg [15:0] high_freq_detect_level;
   reg [15:0] overtorque_level_setting;
   reg [15:0] overtorque_time_setting;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg [15:0] otq_cnt;
   reg otq_det;
   reg ref_loss_d;
   reg fault_d;
   // ahb address-phase capture
   reg ph_wr;
   reg ph_rd;
   reg [11:0] ph_addr;

   // true when f lies within +/- w of centre
   function in_band;
      input [15:0] f;
      input [15:0] c;
      input [15:0] w;
      reg [16:0] lo;
      reg [16:0] hi;
      begin
         // lower bound clips at zero instead of wrapping
         lo = (c > w) ? {1'b0, c - w} : 17'h00000;
         hi = {1'b0, c} + {1'b0, w};
         in_band = ({1'b0, f} >= lo) && ({1'b0, f} <= hi);
      end
   endfunction

   // overtorque qualified only after the level holds for the set time
   // a fall to or below the level restarts the count
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         otq_cnt <= 16'h0000;
         otq_det <= 1'b0;
      end else if (output_torque > overtorque_level_setting) begin
         if (otq_cnt >= overtorque_time_setting) begin
            otq_det <= 1'b1;
         end else begin
            otq_cnt <= otq_cnt + 16'h0001;
         end
      end else begin
         otq_cnt <= 16'h0000;
         otq_det <= 1'b0;
      end
   end

   // detection events stretched to the documented hold time
   wire ref_loss_hold;
   wire fault_evt;
   wire fault_hold;
   assign fault_evt = major_fault & ~operator_watchdog_fault & ~operator_transmission_fault;

   scos_pulse_stretch #(
      .HOLD_CYC(PULSE_CYC)
   ) u_refloss_hold (
      .core_clk(core_clk),
      .nrst(nrst),
      .event_in(ref_loss),
      .stretched(ref_loss_hold)
   );

   // the fault level itself also keeps the contact closed
   scos_pulse_stretch #(
      .HOLD_CYC(PULSE_CYC)
   ) u_fault_hold (
      .core_clk(core_clk),
      .nrst(nrst),
      .event_in(fault_evt),
      .stretched(fault_hold)
   );

   // condition mux shared by all three terminals
   function cond_of;
      input [3:0] code;
      input [13:0] c;
      begin
         case (code)
            `SCOS_C_RUN: cond_of = c[0];
            `SCOS_C_ZERO: cond_of = c[1];
            `SCOS_C_AGREE: cond_of = c[2];
            `SCOS_C_AGPT: cond_of = c[3];
            `SCOS_C_FDET1: cond_of = c[4];
            `SCOS_C_FDET2: cond_of = c[5];
            `SCOS_C_READY: cond_of = c[6];
            `SCOS_C_UV: cond_of = c[7];
            `SCOS_C_BB: cond_of = c[8];
            `SCOS_C_REFOP: cond_of = c[9];
            `SCOS_C_RUNOP: cond_of = c[10];
            `SCOS_C_OTQ: cond_of = c[11];
            `SCOS_C_REFMISS: cond_of = c[12];
            `SCOS_C_FAULT: cond_of = c[13];
            // reserved and unused codes stay open
            default: cond_of = 1'b0;
         endcase
      end
   endfunction

   reg [13:0] conds;
   always @* begin
      conds[0] = forward_run_cmd | reverse_run_cmd | output_voltage_on;
      conds[1] = output_freq < min_freq;
      conds[2] = in_band(output_freq, freq_reference, agreement_width_setting);
      conds[3] = accel_decel_done &
         in_band(output_freq, agreement_point_setting, agreement_width_setting);
      conds[4] = output_freq <= low_freq_detect_level;
      conds[5] = output_freq >= high_freq_detect_level;
      conds[6] = drive_ready;
      conds[7] = undervoltage;
      conds[8] = output_shut_off;
      conds[9] = ref_from_operator;
      conds[10] = run_from_keypad;
      conds[11] = otq_det;
      conds[12] = ref_loss | ref_loss_hold;
      conds[13] = fault_evt | fault_hold;
   end

   // terminals re-evaluated every clock
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         relay_contact_terminal <= 1'b0;
         open_collector_terminal <= 1'b0;
         second_open_collector_terminal <= 1'b0;
      end else begin
         relay_contact_terminal <= cond_of(relay2_output_select, conds);
         open_collector_terminal <= cond_of(opencollector_output_select, conds);
         second_open_collector_terminal <= cond_of(relay1_output_select, conds);
      end
   end

   // rising edges of ref loss, fault, overtorque raise interrupts
   // bit order matches the status register
   wire [2:0] evt;
   reg otq_d;
   assign evt = {otq_det & ~otq_d, fault_evt & ~fault_d, ref_loss & ~ref_loss_d};

   // ahb-lite: zero wait states, always okay
   // hreadyout and hresp keep their reset values, so no wait state ever
   wire take;
   assign take = hsel & hready & htrans[1];
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
         ph_addr <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ph_wr <= take & hwrite;
         ph_rd <= take & ~hwrite;
         if (take) begin
            ph_addr <= haddr;
         end
      end
   end

   // register writes; hardware set wins over write-one-to-clear
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // every select parked on the unused code until software sets it
         relay2_output_select <= `SCOS_SEL_FIELD_RST;
         opencollector_output_select <= `SCOS_SEL_FIELD_RST;
         relay1_output_select <= `SCOS_SEL_FIELD_RST;
         min_freq <= `SCOS_FREQ_RST;
         agreement_point_setting <= `SCOS_FREQ_RST;
         agreement_width_setting <= `SCOS_WIDTH_RST;
         low_freq_detect_level <= `SCOS_DETECT_RST;
         high_freq_detect_level <= `SCOS_DETECT_RST;
         overtorque_level_setting <= `SCOS_OTQ_LVL_RST;
         overtorque_time_setting <= `SCOS_OTQ_TIME_RST;
         irq_stat <= `SCOS_MASK_RST;
         irq_mask <= `SCOS_MASK_RST;
         ref_loss_d <= 1'b0;
         fault_d <= 1'b0;
         otq_d <= 1'b0;
         irq <= 1'b0;
      end else begin
         ref_loss_d <= ref_loss;
         fault_d <= fault_evt;
         otq_d <= otq_det;
         irq <= |(irq_stat & irq_mask);
         if (ph_wr) begin
            case (ph_addr)
               `SCOS_OFF_SEL: begin
                  // field positions follow the select layout
                  relay2_output_select <= hwdata[`SCOS_SEL_RLY_LSB +: 4];
                  opencollector_output_select <= hwdata[`SCOS_SEL_OC_LSB +: 4];
                  relay1_output_select <= hwdata[`SCOS_SEL_OC2_LSB +: 4];
               end
               `SCOS_OFF_FREQ_CFG: begin
                  min_freq <= hwdata[15:0];
                  agreement_point_setting <= hwdata[31:16];
               end
               `SCOS_OFF_WIDTH: agreement_width_setting <= hwdata[15:0];
               `SCOS_OFF_DETECT: begin
                  low_freq_detect_level <= hwdata[15:0];
                  high_freq_detect_level <= hwdata[31:16];
               end
               `SCOS_OFF_OUTS: begin
                  overtorque_level_setting <= hwdata[15:0];
                  overtorque_time_setting <= hwdata[31:16];
               end
               `SCOS_OFF_IRQ_MASK: irq_mask <= hwdata[2:0];
               default: ;
            endcase
         end
         if (ph_wr && ph_addr == `SCOS_OFF_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[2:0]) | evt;
         end else begin
            irq_stat <= irq_stat | evt;
         end
      end
   end

   // implemented bits of each config word; zero marks no bypass
   function [31:0] field_mask;
      input [11:0] a;
      begin
         case (a)
            `SCOS_OFF_SEL: field_mask = 32'h00000FFF;
            `SCOS_OFF_FREQ_CFG: field_mask = 32'hFFFFFFFF;
            `SCOS_OFF_WIDTH: field_mask = 32'h0000FFFF;
            `SCOS_OFF_DETECT: field_mask = 32'hFFFFFFFF;
            `SCOS_OFF_OUTS: field_mask = 32'hFFFFFFFF;
            `SCOS_OFF_IRQ_MASK: field_mask = 32'h00000007;
            // status is volatile, so a read behind its clear is not bypassed
            default: field_mask = 32'h00000000;
         endcase
      end
   endfunction

   // read data registered at the address phase; a read right behind a
   // write to the same word would otherwise return the old contents
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h00000000;
      end else if (take & ~hwrite & ph_wr & (ph_addr == haddr) &
         (field_mask(haddr) != 32'h00000000)) begin
         hrdata <= hwdata & field_mask(haddr);
      end else if (take & ~hwrite) begin
         case (haddr)
            `SCOS_OFF_SEL: hrdata <= {20'h00000, relay1_output_select,
               opencollector_output_select, relay2_output_select};
            `SCOS_OFF_FREQ_CFG: hrdata <= {agreement_point_setting, min_freq};
            `SCOS_OFF_WIDTH: hrdata <= {16'h0000, agreement_width_setting};
            `SCOS_OFF_DETECT: hrdata <= {high_freq_detect_level, low_freq_detect_level};
            `SCOS_OFF_OUTS: hrdata <= {overtorque_time_setting, overtorque_level_setting};
            `SCOS_OFF_IRQ_STAT: hrdata <= {25'h0000000, second_open_collector_terminal,
               open_collector_terminal, relay_contact_terminal, 1'b0, irq_stat};
            `SCOS_OFF_IRQ_MASK: hrdata <= {29'h00000000, irq_mask};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* File: testbench/scos_selector_asserts.sv */
`timescale 1ns/100ps
// checks terminals against a shadow of the select and mask registers
module scos_chk #(
   parameter [22:0] PULSE_CYC = 23'd20
) (
   input wire core_clk,
   input wire nrst,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire forward_run_cmd,
   input wire reverse_run_cmd,
   input wire output_voltage_on,
   input wire drive_ready,
   input wire undervoltage,
   input wire output_shut_off,
   input wire ref_from_operator,
   input wire run_from_keypad,
   input wire ref_loss,
   input wire relay_contact_terminal,
   input wire open_collector_terminal,
   input wire second_open_collector_terminal,
   input wire irq
);
   logic pend;
   logic wr;
   logic [11:0] aq;
   logic [11:0] sel;
   logic [2:0] msk;
   logic [2:0] cv;
   logic [2:0] ok;
   logic [5:0] v;
   wire [2:0] t = {second_open_collector_terminal, open_collector_terminal,
      relay_contact_terminal};
   // level codes only; the others need settings or stretching
   function automatic logic cf(input logic [3:0] c, input logic [5:0] lv);
      case (c)
         4'h0: cf = lv[5];
         4'h6: cf = lv[4];
         4'h7: cf = lv[3];
         4'h8: cf = lv[2];
         4'h9: cf = lv[1];
         4'hA: cf = lv[0];
         default: cf = 1'b0;
      endcase
   endfunction
   // shadow registers update at the data phase edge, as the slave does
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pend <= 1'b0;
         wr <= 1'b0;
         aq <= 12'h000;
         sel <= 12'hFFF;
         msk <= 3'h0;
      end else begin
         pend <= hsel & hready & htrans[1];
         wr <= hwrite;
         aq <= haddr;
         if (pend && wr && aq == 12'h000) sel <= hwdata[11:0];
         if (pend && wr && aq == 12'h018) msk <= hwdata[2:0];
      end
   end
   // condition and code class per terminal
   always_comb begin
      v = {forward_run_cmd | reverse_run_cmd | output_voltage_on, drive_ready,
         undervoltage, output_shut_off, ref_from_operator, run_from_keypad};
      for (int i = 0; i < 3; i++) begin
         cv[i] = cf(sel[4*i+:4], v);
         ok[i] = sel[4*i+:4] inside {4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hF};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_loss;
      sel[3:0] == 4'hC && $rose(ref_loss);
   endsequence
   sequence s_hold;
      ##2 relay_contact_terminal [*8];
   endsequence
   relay_follows_a: assert property (ok[0] |=> t[0] == $past(cv[0]))
      else $error("relay terminal off its select");
   oc_follows_a: assert property (ok[1] |=> t[1] == $past(cv[1]))
      else $error("open collector off its select");
   oc2_follows_a: assert property (ok[2] |=> t[2] == $past(cv[2]))
      else $error("second open collector off its select");
   loss_hold_a: assert property (s_loss |-> s_hold)
      else $error("reference loss not held");
   mask_quiet_a: assert property (msk == 3'h0 && $past(msk) == 3'h0 |-> !irq)
      else $error("irq while masked");
   loss_irq_a: assert property (msk[0] && $rose(ref_loss) |-> ##[1:4] irq)
      else $error("irq missing on reference loss");
   sel_readback_a: assert property (pend && !wr && aq == 12'h000 |->
      hrdata[11:0] == sel)
      else $error("select readback wrong");
   unmapped_zero_a: assert property (pend && !wr && aq >= 12'h01C |->
      hrdata == 32'h0 && hreadyout && !hresp)
      else $error("unmapped read not zero");
endmodule

bind scos_selector scos_chk #(.PULSE_CYC(PULSE_CYC)) i_scos_chk (
   .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .forward_run_cmd(forward_run_cmd),
   .reverse_run_cmd(reverse_run_cmd), .output_voltage_on(output_voltage_on),
   .drive_ready(drive_ready), .undervoltage(undervoltage),
   .output_shut_off(output_shut_off), .ref_from_operator(ref_from_operator),
   .run_from_keypad(run_from_keypad), .ref_loss(ref_loss),
   .relay_contact_terminal(relay_contact_terminal),
   .open_collector_terminal(open_collector_terminal),
   .second_open_collector_terminal(second_open_collector_terminal), .irq(irq));

/* File: testbench/scos_field_model.sv */
`timescale 1ns/100ps
// field side: a relay coil and two pulled-up open-collector inputs
module scos_field_model (
   input wire relay_contact_terminal,
   input wire open_collector_terminal,
   input wire second_open_collector_terminal,
   output wire relay_closed,
   output wire [1:0] oc_line
);
   // an off transistor lets the pull-up win, so the line is never left floating
   assign oc_line = ~{second_open_collector_terminal, open_collector_terminal};
   assign relay_closed = relay_contact_terminal;
endmodule

/* File: testbench/test_scos_selector.sv */
`timescale 1ns/100ps
// drives the selector over the register bus and judges its terminals
module test_scos_selector;
   localparam [22:0] PULSE = 23'd20;
   logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, q;
   logic [7:0] sb;
   logic [15:0] freq, torq, fref;
   logic done, loss, flt, wdf, txf, rly, oc, oc2, rclosed;
   logic [1:0] ocl;
   int errors, check_count;
   wire [2:0] outs = {oc2, oc, rly};
   scos_selector #(.PULSE_CYC(PULSE)) i_scos_selector (
      .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .forward_run_cmd(sb[7]), .reverse_run_cmd(sb[6]), .output_voltage_on(sb[5]),
      .accel_decel_done(done), .output_freq(freq), .freq_reference(fref),
      .drive_ready(sb[4]), .undervoltage(sb[3]), .output_shut_off(sb[2]),
      .ref_from_operator(sb[1]), .run_from_keypad(sb[0]), .output_torque(torq),
      .ref_loss(loss), .major_fault(flt), .operator_watchdog_fault(wdf),
      .operator_transmission_fault(txf), .relay_contact_terminal(rly),
      .open_collector_terminal(oc), .second_open_collector_terminal(oc2), .irq(irq));
   scos_field_model i_scos_field_model (.relay_contact_terminal(rly),
      .open_collector_terminal(oc), .second_open_collector_terminal(oc2),
      .relay_closed(rclosed), .oc_line(ocl));
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one single transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_reset();
      bus(1'b0, 12'h000, 32'h0);
      chk(q[11:0], 12'hFFF, "sel reset");
      chk(outs, 3'h0, "outs reset");
      bus(1'b0, 12'h100, 32'h0);
      chk(q, 32'h0, "unmapped");
   endtask
   // each level code on all three terminals, then reserved codes
   task automatic t_simple();
      logic [3:0] c [10] = '{4'h0, 4'h0, 4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hF};
      logic [7:0] b [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
         8'hFF, 8'hFF};
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, 12'h000, {20'h0, c[i], c[i], c[i]});
         sb <= b[i];
         cyc(2);
         chk(outs, (c[i] > 4'hC) ? 3'h0 : 3'h7, "level on");
         sb <= 8'h00;
         cyc(2);
         chk(outs, 3'h0, "level off");
      end
      bus(1'b1, 12'h000, 32'h0000009A);
      sb <= 8'h02;
      cyc(2);
      chk(outs, 3'h2, "independent");
      chk(ocl, 2'h2, "field line");
      sb <= 8'h00;
   endtask
   // boundaries of the frequency comparisons: code, done, expect, frequency
   task automatic t_freq();
      logic [23:0] tv [12] = '{24'h110063, 24'h100064, 24'h4100C8, 24'h4000C9,
         24'h51012C, 24'h50012B, 24'h2101FE, 24'h2001FF, 24'h2101EA, 24'h3303ED,
         24'h3003ED, 24'h3203F3};
      bus(1'b1, 12'h004, 32'h03E80064);
      bus(1'b1, 12'h008, 32'h0000000A);
      bus(1'b1, 12'h00C, 32'h012C00C8);
      foreach (tv[i]) begin
         bus(1'b1, 12'h000, {20'h0, {3{tv[i][23:20]}}});
         freq <= tv[i][15:0];
         done <= tv[i][17];
         cyc(2);
         chk(outs, {3{tv[i][16]}}, "freq code");
      end
      // reference moves; band low edge clips at zero
      bus(1'b1, 12'h000, 32'h00000222);
      fref <= 16'h0005;
      freq <= 16'h0000;
      cyc(2);
      chk(outs, 3'h7, "band clip");
      freq <= 16'h0010;
      cyc(2);
      chk(outs, 3'h0, "band clip top");
      fref <= 16'h01F4;
   endtask
   task automatic t_pulse();
      bus(1'b1, 12'h018, 32'h7);
      bus(1'b1, 12'h000, 32'hFFC);
      loss <= 1'b1;
      cyc(1);
      loss <= 1'b0;
      cyc(PULSE - 2);
      chk(rly, 1'h1, "stretch held");
      chk(irq, 1'h1, "irq on");
      cyc(8);
      chk(rly, 1'h0, "stretch end");
      bus(1'b0, 12'h014, 32'h0);
      chk(q[2:0], 3'h1, "stat loss");
      bus(1'b1, 12'h014, 32'h1);
      cyc(2);
      chk(irq, 1'h0, "irq clear");
      bus(1'b1, 12'h018, 32'h0);
      bus(1'b1, 12'h000, 32'hFFE);
      flt <= 1'b1;
      cyc(3);
      chk(rly, 1'h1, "fault");
      chk(rclosed, 1'h1, "fault coil");
      chk(irq, 1'h0, "irq masked");
      flt <= 1'b0;
      bus(1'b0, 12'h014, 32'h0);
      chk(q[1], 1'h1, "stat fault");
      bus(1'b1, 12'h014, 32'h7);
      // operator link faults never close the fault contact
      cyc(PULSE);
      wdf <= 1'b1;
      flt <= 1'b1;
      cyc(3);
      chk(rly, 1'h0, "watchdog excluded");
      {wdf, txf} <= 2'b01;
      cyc(3);
      chk(rly, 1'h0, "link excluded");
      flt <= 1'b0;
      cyc(1);
      txf <= 1'b0;
   endtask
   // overtorque needs level exceeded for time plus one edges
   task automatic t_otq();
      bus(1'b1, 12'h010, 32'h00030032);
      bus(1'b1, 12'h000, 32'hFFB);
      torq <= 16'h003C;
      cyc(5);
      chk(rly, 1'h0, "otq early");
      cyc(1);
      chk(rly, 1'h1, "otq set");
      torq <= 16'h0000;
      cyc(4);
      chk(rly, 1'h0, "otq drop");
      bus(1'b0, 12'h014, 32'h0);
      chk(q[2:0], 3'h4, "stat torque");
   endtask
   // free running clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      {hsel, hwrite, done, loss, flt, wdf, txf} = 7'h00;
      fref = 16'h01F4;
      haddr = 12'h000;
      htrans = 2'h0;
      hwdata = 32'h0;
      sb = 8'h00;
      freq = 16'h0000;
      torq = 16'h0000;
      errors = 0;
      check_count = 0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_simple();
      t_freq();
      t_pulse();
      t_otq();
      conclude();
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      cyc(20000);
      errors++;
      conclude();
   end
endmodule
